// *** sim/sfrc_read_asserts.sv ***
// Purpose: wire checks on the flash read link
// Assumes: sampled on the host core clock, well above sck
// Notes: watches both ends across the shared interface
`timescale 1ns/100ps
module sfrc_read_asserts
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic quad_lane_enable_bit
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic sck_q; // sck one sample ago
  logic [7:0] rises; // rising sck edges in this frame, saturating
  // edge detect on the sampled serial clock
  always_ff @(posedge core_clk)
    sck_q <= sck;
  // count clocks since select fell
  always_ff @(posedge core_clk)
  begin
    if (reset || cs_n)
      rises <= 8'h00;
    else if (sck && !sck_q && rises != 8'hff)
      rises <= rises + 8'h01;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_release_deselect: assert property (cs_n |-> dev_io_oe == 4'h0)
    else $error("device drives a line while deselected");
  a_select_held: assert property (sck |-> !cs_n)
    else $error("serial clock high outside a frame");
  a_first_data_edge: assert property ($rose(|dev_io_oe)
    |-> rises inside {8'h20, 8'h28, 8'h40})
    else $error("data started after a wrong clock count");
  a_dev_fall_only: assert property (!cs_n && !$past(cs_n)
    && !$stable(dev_io_o & dev_io_oe) |-> $fell(sck))
    else $error("device output moved off a falling edge");
  a_host_fall_only: assert property (host_io_oe[0] && $past(host_io_oe[0])
    && !$stable(host_io_o[0]) |-> $fell(sck))
    else $error("host line moved off a falling edge");
  a_quad_gate: assert property (|dev_io_oe[3:2] |-> quad_lane_enable_bit)
    else $error("upper lines driven without quad enable");
  a_lane_sets: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal set of driven lines");
  a_host_yields: assert property ($rose(|dev_io_oe) |-> ##[0:1] host_io_oe == 4'h0)
    else $error("host still drives once data starts");
  // main scenarios reached
  cover property ($rose(dev_io_oe == 4'h3));
  cover property ($rose(dev_io_oe == 4'hf));
  cover property ($rose(cs_n));
endmodule

// *** sim/tb_serial_flash_read_commands.sv ***
// Purpose: end-to-end read checks of host and flash device
// Assumes: memory is a fixed pattern of source, page and byte
// Notes: four pages keep the array wrap short
`timescale 1ns/100ps
module tb_serial_flash_read_commands import sfrc_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int PC = 4; // pages, small so the array wrap is cheap
  logic core_clk = 0, reset = 1, bin = 0, qe = 0, cmd_valid = 0;
  logic [7:0] op = 0, mem_data, rd_data;
  logic [23:0] addr = 0;
  logic [15:0] len = 0;
  logic cmd_ready, rd_valid, cmd_done;
  sfrc_src_type mem_src;
  logic [11:0] mem_page;
  logic [9:0] mem_byte;
  logic [31:0] lfsr = 32'hd231a7d7;
  logic [7:0] ops[8] = '{8'hd2, 8'hd4, 8'hd1, 8'hd6, 8'hd3, 8'h3b, 8'h6b, 8'h5a};
  logic [7:0] exp_q[$]; // bytes the model expects next
  int mismatches = 0, total_checks = 0;
  always #5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // design and checker
  // ----------------------------------------------------------------
  sfrc_link_if link ();
  sfrc_host #(.HALF_CYCLES(3)) i_sfrc_host (.core_clk(core_clk), .reset(reset), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(op), .cmd_addr(addr),
    .cmd_len(len), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_done(cmd_done));
  sfrc_flash_dev #(.PAGE_COUNT(PC)) i_sfrc_flash_dev (.link(link), .reset(reset),
    .binary_page_size(bin), .quad_lane_enable_bit(qe), .mem_data(mem_data),
    .mem_src(mem_src), .mem_page(mem_page), .mem_byte(mem_byte));
  sfrc_read_asserts i_sfrc_read_asserts (.core_clk(core_clk), .reset(reset),
    .sck(link.sck), .cs_n(link.cs_n), .host_io_o(link.host_io_o),
    .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe),
    .quad_lane_enable_bit(qe));
  // ----------------------------------------------------------------
  // memory pattern, bench helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input int s, input int p, input int b);
    return 8'(b * 5 + (b >> 8) * 29 + p * 37 + s * 85);
  endfunction
  assign mem_data = pat(int'(mem_src), int'(mem_page), int'(mem_byte));
  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // bounded wait for ready (0) or done (1)
  task automatic await(input bit done);
    int t;
    for (t = 0; t < 20000 && (done ? cmd_done : cmd_ready) !== 1'b1; t++)
      @(negedge core_clk);
    if (t == 20000)
    begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
    end
  endtask
  // every received byte against the model
  always @(negedge core_clk)
  begin
    if (rd_valid === 1'b1)
      check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end
  // model the command, then issue it and wait for its end
  task automatic run(input logic [7:0] o, input logic [23:0] a, input int n);
    int pg, b, src, last;
    bit arr;
    last = bin ? 511 : 527;
    pg = bin ? int'(a[20:9]) : int'(a[21:10]);
    b = bin ? int'(a[8:0]) : int'(a[9:0]);
    src = (o == 8'hd4 || o == 8'hd1) ? 1 : (o == 8'hd6 || o == 8'hd3) ? 2 : 0;
    arr = o == 8'h3b || (o == 8'h6b && qe);
    if (src != 0)
      pg = 0;
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(src == 0 && o != 8'hd2 && !arr ? 8'hff : pat(src, pg, b));
      if (b >= last)
      begin
        b = 0;
        if (arr)
          pg = (pg + 1) % PC;
      end
      else
        b++;
    end
    op = o;
    addr = a;
    len = 16'(n);
    await(0);
    cmd_valid = 1;
    @(negedge core_clk);
    cmd_valid = 0;
    await(1);
    check(8'(exp_q.size()), 8'h00);
    exp_q.delete();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 0;
    run(8'hd2, 24'h000a0e, 4);
    bin = 1;
    run(8'hd2, 24'h0007fe, 3);
    for (int i = 0; i < 8; i++)
    begin
      bin = i[2];
      run(ops[1 + i % 4], i[2] ? 24'hfffffe : 24'hfffe0e, 3);
    end
    bin = 0;
    run(8'h3b, 24'h000e0f, 3);
    qe = 1;
    bin = 1;
    run(8'h6b, 24'h0007ff, 3);
    qe = 0;
    run(8'h6b, 24'h0007ff, 2);
    for (int i = 0; i < 12; i++)
    begin
      lfsr = step(lfsr);
      bin = lfsr[3];
      qe = lfsr[4];
      run(ops[lfsr[2:0]], lfsr[31:8] & 24'hc007ff, int'(lfsr[11:9]));
    end
    test_done();
  end
endmodule

// *** src/sfrc_flash_dev.sv ***
// Purpose: read command engine of a serial flash device
// Assumes: runs on the serial clock only, array and buffers are read
//   through an asynchronous read port outside this module
// Notes: inputs sampled on rising clock, line outputs change on falling clock
// Overview of operation
// R1: page read: opcode, address, four dummy bytes
// R2: 528 pages: upper 12 page, lower 10 byte
// R3: 512 pages: bits 20..9 page, 8..0 byte
// R4: page read wraps to same page start
// R5: host keeps select low whole command
// R6: select rising ends command, releases lines
// R7: array reads never touch buffer contents
// R8: buffer opcodes select buffer one or two
// R9: 528 buffers: 14 ignored, 10 offset bits
// R10: 512 buffers: 15 ignored, 9 offset bits
// R11: only fast buffer reads take dummy byte
// R12: buffer read wraps to buffer start
// R13: dual read: 3b, address, one dummy
// R14: dual: two bits per clock, msb upper
// R15: dual/quad cross pages, wrap array end
// R16: quad needs enable bit, frees extra lines
// R17: quad read: 6b, address, one dummy
// R18: quad: high nibble then low nibble
// R19: 512 pages: flat address plus one dummy
// R20: sample rising edges, drive falling edges
`timescale 1ns/100ps
module sfrc_flash_dev
  import sfrc_pkg::*;
#(
  parameter int PAGE_COUNT = SFRC_PAGE_COUNT
)
(
  sfrc_link_if.dev link,
  input wire logic reset,
  input wire logic binary_page_size,
  input wire logic quad_lane_enable_bit,
  input wire logic [7:0] mem_data,
  output sfrc_src_type mem_src,
  output logic [SFRC_PAGE_BITS-1:0] mem_page,
  output logic [SFRC_BYTE_BITS-1:0] mem_byte
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the page index is 12 bits wide, more pages cannot be addressed
  if (PAGE_COUNT < 2 || PAGE_COUNT > SFRC_PAGE_COUNT)
  begin : g_bad_pages
    $error("sfrc_flash_dev: PAGE_COUNT out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE
  } sfrc_dev_state_type;

  sfrc_dev_state_type state; // command phase
  sfrc_cmd_type cmd; // command taken from the opcode
  logic [5:0] bit_cnt; // clocks within the phase
  logic [2:0] chunk; // clock within the current data byte
  logic [22:0] shift_in; // collected serial input bits
  logic [23:0] addr_word; // full address including this clock's bit
  logic [7:0] op_word; // full opcode including this clock's bit
  sfrc_cmd_type op_cmd; // decode of op_word
  logic op_ok; // opcode is served here
  logic bin_meta; // page size, first stage
  logic bin_sync; // page size, usable
  logic qe_meta; // quad enable, first stage
  logic qe_sync; // quad enable, usable
  logic [9:0] last_byte; // last byte of page or buffer
  logic byte_done; // last clock of a data byte
  logic last_page; // page index at the array end

  assign addr_word = {shift_in, link.io[0]};
  assign op_word = {shift_in[6:0], link.io[0]};
  assign op_cmd = sfrc_decode(op_word);
  // quad opcode is refused unless the enable bit is set
  assign op_ok = (op_cmd != CMD_NONE) && ((op_cmd != CMD_QUAD) || qe_sync); // [R16]
  assign last_byte = bin_sync ? SFRC_BIN_LAST : SFRC_STD_LAST;
  assign byte_done = (state == ST_DATA) && (chunk == sfrc_last_chunk(cmd));
  assign last_page = (mem_page == SFRC_PAGE_BITS'(PAGE_COUNT - 1));

  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  // bits for the current clock, msb of the byte goes out first
  function automatic logic [3:0] lane_bits(input logic [7:0] data,
    input logic [2:0] ck, input sfrc_cmd_type c);
    logic [7:0] d;
    d = 8'h00;
    d = data << (ck * sfrc_lanes(c));
    case (c)
      CMD_DUAL: return {2'b00, d[7:6]}; // [R14]
      CMD_QUAD: return d[7:4]; // [R18]
      default: return {2'b00, d[7], 1'b0};
    endcase
  endfunction

  // lines the device drives for the command
  function automatic logic [3:0] lane_mask(input sfrc_cmd_type c);
    case (c)
      CMD_DUAL: return 4'h3;
      CMD_QUAD: return 4'hf; // extra lines serve as data only in quad
      default: return 4'h2; // single serial output line
    endcase
  endfunction

  // ----------------------------------------------------------------
  // configuration synchronisers
  // ----------------------------------------------------------------
  // straps come from the core side, hold them steady between commands
  always_ff @(posedge link.sck)
  begin
    bin_meta <= binary_page_size;
    bin_sync <= bin_meta;
    qe_meta <= quad_lane_enable_bit;
    qe_sync <= qe_meta;
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // rising edges collect opcode, address and dummy clocks
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n) // [R6]
    begin
      state <= ST_OPCODE;
      cmd <= CMD_NONE;
      bit_cnt <= 6'h00;
      chunk <= 3'h0;
      shift_in <= 23'h000000;
    end
    else if (reset)
    begin
      state <= ST_OPCODE;
      cmd <= CMD_NONE;
      bit_cnt <= 6'h00;
      chunk <= 3'h0;
      shift_in <= 23'h000000;
    end
    else
    begin
      shift_in <= addr_word[22:0]; // [R20]
      unique case (state)
        ST_OPCODE:
        begin
          if (bit_cnt == SFRC_OPCODE_BITS - 6'h01)
          begin
            cmd <= op_cmd; // [R8]
            bit_cnt <= 6'h00;
            // unserved opcodes leave every line released until deselect
            state <= op_ok ? ST_ADDR : ST_IGNORE;
          end
          else
            bit_cnt <= bit_cnt + 6'h01;
        end
        ST_ADDR:
        begin
          if (bit_cnt == SFRC_ADDR_BITS - 6'h01)
          begin
            bit_cnt <= 6'h00;
            chunk <= 3'h0;
            // slow buffer reads go straight to data
            state <= (sfrc_dummy(cmd) == SFRC_NO_DUMMY) ? ST_DATA : ST_DUMMY; // [R11]
          end
          else
            bit_cnt <= bit_cnt + 6'h01;
        end
        ST_DUMMY:
        begin
          // four dummy bytes for page read, one for dual, quad, fast buffer
          if (bit_cnt == sfrc_dummy(cmd) - 6'h01) // [R1] [R13] [R17] [R19]
          begin
            bit_cnt <= 6'h00;
            chunk <= 3'h0;
            state <= ST_DATA;
          end
          else
            bit_cnt <= bit_cnt + 6'h01;
        end
        ST_DATA:
        begin
          // one clock per bit, per bit pair or per nibble
          chunk <= byte_done ? 3'h0 : chunk + 3'h1; // [R14] [R18]
        end
        ST_IGNORE:
        begin
          state <= ST_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read address
  // ----------------------------------------------------------------
  // only a read port exists, so no command can alter a buffer
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      mem_src <= SRC_ARRAY;
      mem_page <= '0;
      mem_byte <= '0;
    end
    else if (reset)
    begin
      mem_src <= SRC_ARRAY;
      mem_page <= '0;
      mem_byte <= '0;
    end
    else if (state == ST_ADDR && bit_cnt == SFRC_ADDR_BITS - 6'h01)
    begin
      unique case (cmd)
        CMD_BUF1_FAST, CMD_BUF1_SLOW:
        begin
          mem_src <= SRC_BUF1; // [R8]
          mem_page <= '0;
        end
        CMD_BUF2_FAST, CMD_BUF2_SLOW:
        begin
          mem_src <= SRC_BUF2; // [R8]
          mem_page <= '0;
        end
        default:
        begin
          mem_src <= SRC_ARRAY; // [R7]
          if (bin_sync)
            mem_page <= addr_word[SFRC_BIN_PAGE_LSB +: SFRC_PAGE_BITS]; // [R3] [R19]
          else
            mem_page <= addr_word[SFRC_STD_PAGE_LSB +: SFRC_PAGE_BITS]; // [R2]
        end
      endcase
      // leading address bits above the offset field are dropped
      if (bin_sync)
        mem_byte <= {1'b0, addr_word[SFRC_BIN_PAGE_LSB-1:0]}; // [R3] [R10]
      else
        mem_byte <= addr_word[SFRC_STD_PAGE_LSB-1:0]; // [R2] [R9]
    end
    else if (byte_done)
    begin
      // an offset past the end is read once, then wraps to 0 rather than counting on
      if (mem_byte >= last_byte)
      begin
        mem_byte <= '0; // [R4] [R12]
        if (cmd == CMD_DUAL || cmd == CMD_QUAD)
          mem_page <= last_page ? '0 : mem_page + 1'b1; // [R15]
      end
      else
        mem_byte <= mem_byte + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output lines
  // ----------------------------------------------------------------
  // falling edges drive data, deselect releases every line at once
  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n) // [R6]
    begin
      link.dev_io_o <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end
    else if (reset)
    begin
      link.dev_io_o <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end
    else if (state == ST_DATA)
    begin
      link.dev_io_o <= lane_bits(mem_data, chunk, cmd); // [R20]
      link.dev_io_oe <= lane_mask(cmd); // [R16]
    end
    else
    begin
      link.dev_io_o <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end
  end

endmodule

// *** src/sfrc_host.sv ***
// Purpose: host master issuing flash read commands over the link
// Assumes: core clock runs well above the serial clock it divides down
// Notes: serial clock idles low, one command at a time
`timescale 1ns/100ps
module sfrc_host
  import sfrc_pkg::*;
#(
  parameter int HALF_CYCLES = SFRC_HALF_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset,
  sfrc_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cmd_done
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the input synchroniser needs three cycles of each half period
  if (HALF_CYCLES < 3 || HALF_CYCLES > 255)
  begin : g_bad_half
    $error("sfrc_host: HALF_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_TRAIL} sfrc_host_state_type;

  sfrc_host_state_type state; // frame phase
  sfrc_cmd_type cmd; // command being sent
  logic [7:0] div; // core cycles in this half period
  logic tick; // half period elapsed
  logic [63:0] tx; // opcode, address and dummy bits, msb first
  logic [6:0] tx_left; // serial input clocks still to go
  logic [15:0] len_left; // data bytes still to read
  logic [2:0] chunk; // clock within a data byte
  logic [7:0] rx; // byte being gathered
  logic last; // final rising edge seen
  logic [3:0] io_meta; // line levels, first stage
  logic [3:0] io_sync; // line levels, usable

  assign tick = (div == 8'(HALF_CYCLES - 1));

  // ----------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    io_meta <= link.io;
    io_sync <= io_meta;
  end

  // ----------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset || state == H_IDLE || tick)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    rd_valid <= 1'b0;
    cmd_done <= 1'b0;
    if (reset)
    begin
      state <= H_IDLE;
      cmd <= CMD_NONE;
      cmd_ready <= 1'b0;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.host_io_o <= 4'h0;
      link.host_io_oe <= 4'h0;
      tx <= 64'h0;
      tx_left <= 7'h00;
      len_left <= 16'h0000;
      chunk <= 3'h0;
      rx <= 8'h00;
      rd_data <= 8'h00;
      last <= 1'b0;
    end
    else
    begin
      unique case (state)
        H_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            cmd <= sfrc_decode(cmd_opcode);
            tx <= {cmd_opcode, cmd_addr, 32'h0} << 1;
            tx_left <= 7'(SFRC_OPCODE_BITS + SFRC_ADDR_BITS)
              + 7'(sfrc_dummy(sfrc_decode(cmd_opcode)));
            len_left <= cmd_len;
            chunk <= 3'h0;
            last <= 1'b0;
            // select stays low for the whole frame
            link.cs_n <= 1'b0; // [R5]
            link.host_io_o <= {3'h0, cmd_opcode[7]}; // [R20]
            link.host_io_oe <= 4'h1;
            state <= H_RUN;
          end
        end
        H_RUN:
        begin
          if (tick && !link.sck)
          begin
            // rising edge: device samples our bit or we sample its data
            link.sck <= 1'b1;
            if (tx_left != 7'h00)
            begin
              tx_left <= tx_left - 7'h01;
              if (tx_left == 7'h01 && len_left == 16'h0000)
                last <= 1'b1;
            end
            else
            begin
              unique case (cmd)
                CMD_DUAL: rx <= {rx[5:0], io_sync[1:0]}; // [R14]
                CMD_QUAD: rx <= {rx[3:0], io_sync}; // [R18]
                default: rx <= {rx[6:0], io_sync[1]};
              endcase
              if (chunk == sfrc_last_chunk(cmd))
              begin
                chunk <= 3'h0;
                rd_valid <= 1'b1;
                unique case (cmd)
                  CMD_DUAL: rd_data <= {rx[5:0], io_sync[1:0]};
                  CMD_QUAD: rd_data <= {rx[3:0], io_sync};
                  default: rd_data <= {rx[6:0], io_sync[1]};
                endcase
                len_left <= len_left - 16'h0001;
                if (len_left == 16'h0001)
                  last <= 1'b1;
              end
              else
                chunk <= chunk + 3'h1;
            end
          end
          else if (tick)
          begin
            // falling edge: next bit out, or free the line for the device
            link.sck <= 1'b0;
            if (last)
              state <= H_TRAIL;
            if (tx_left != 7'h00)
            begin
              link.host_io_o <= {3'h0, tx[63]}; // [R1] [R11] [R13] [R17]
              tx <= tx << 1;
            end
            else
              link.host_io_oe <= 4'h0;
          end
        end
        H_TRAIL:
        begin
          if (tick)
          begin
            link.cs_n <= 1'b1;
            link.host_io_oe <= 4'h0;
            link.host_io_o <= 4'h0;
            cmd_done <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// *** src/sfrc_link_if.sv ***
// Purpose: serial flash link between host master and flash device
// Assumes: lines idle high through pull-ups when nobody drives them
// Notes: the device enable wins if both ends drive one line
`timescale 1ns/100ps
interface sfrc_link_if;

  // ----------------------------------------------------------------
  // wires
  // ----------------------------------------------------------------
  logic sck; // serial clock, made by the host
  logic cs_n; // chip select, active low
  logic [3:0] host_io_o; // host line values
  logic [3:0] host_io_oe; // host line enables
  logic [3:0] dev_io_o; // device line values
  logic [3:0] dev_io_oe; // device line enables
  logic [3:0] io; // resolved line levels

  // resolve the shared lines, undriven lines read high
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o)
    | (~dev_io_oe & ~host_io_oe);

  modport host (output sck, output cs_n, output host_io_o, output host_io_oe,
    input io);
  modport dev (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);

endinterface

// *** src/sfrc_pkg.sv ***
// Purpose: shared opcodes, geometry and command decode for the flash read link
// Assumes: both ends compile against this package
// Notes: opcode tables are the device's, the host uses them to size its frames
package sfrc_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] SFRC_OP_PAGE_READ = 8'hd2; // single page, wraps in page
  localparam logic [7:0] SFRC_OP_BUF1_FAST = 8'hd4; // buffer one, dummy byte
  localparam logic [7:0] SFRC_OP_BUF1_SLOW = 8'hd1; // buffer one, no dummy
  localparam logic [7:0] SFRC_OP_BUF2_FAST = 8'hd6; // buffer two, dummy byte
  localparam logic [7:0] SFRC_OP_BUF2_SLOW = 8'hd3; // buffer two, no dummy
  localparam logic [7:0] SFRC_OP_DUAL_READ = 8'h3b; // two lanes, crosses pages
  localparam logic [7:0] SFRC_OP_QUAD_READ = 8'h6b; // four lanes, crosses pages

  // ----------------------------------------------------------------
  // frame lengths in serial clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] SFRC_OPCODE_BITS = 6'h08; // opcode clocks
  localparam logic [5:0] SFRC_ADDR_BITS = 6'h18; // three address bytes
  localparam logic [5:0] SFRC_PAGE_DUMMY = 6'h20; // four dummy bytes
  localparam logic [5:0] SFRC_ONE_DUMMY = 6'h08; // one dummy byte
  localparam logic [5:0] SFRC_NO_DUMMY = 6'h00; // data straight after address

  // ----------------------------------------------------------------
  // geometry and address fields
  // ----------------------------------------------------------------
  localparam int SFRC_PAGE_COUNT = 4096; // pages in the array
  localparam int SFRC_PAGE_BITS = 12; // page index width
  localparam int SFRC_BYTE_BITS = 10; // byte-in-page width
  localparam int SFRC_STD_PAGE_LSB = 10; // page field start, 528-byte pages
  localparam int SFRC_BIN_PAGE_LSB = 9; // page field start, 512-byte pages
  localparam int SFRC_STD_PAGE_BYTES = 528; // standard page and buffer size
  localparam int SFRC_BIN_PAGE_BYTES = 512; // binary page and buffer size
  localparam logic [9:0] SFRC_STD_LAST = 10'(SFRC_STD_PAGE_BYTES - 1); // last byte
  localparam logic [9:0] SFRC_BIN_LAST = 10'(SFRC_BIN_PAGE_BYTES - 1); // last byte

  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int SFRC_CORE_CLK_NS = 10; // host core clock period
  localparam int SFRC_SCK_PERIOD_NS = 160; // serial clock period
  localparam int SFRC_HALF_CYCLES = SFRC_SCK_PERIOD_NS / (2 * SFRC_CORE_CLK_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE, CMD_PAGE, CMD_BUF1_FAST, CMD_BUF1_SLOW,
    CMD_BUF2_FAST, CMD_BUF2_SLOW, CMD_DUAL, CMD_QUAD
  } sfrc_cmd_type;

  typedef enum logic [1:0] {SRC_ARRAY, SRC_BUF1, SRC_BUF2} sfrc_src_type;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // opcode to command, unknown opcodes map to none
  function automatic sfrc_cmd_type sfrc_decode(input logic [7:0] op);
    case (op)
      SFRC_OP_PAGE_READ: return CMD_PAGE;
      SFRC_OP_BUF1_FAST: return CMD_BUF1_FAST;
      SFRC_OP_BUF1_SLOW: return CMD_BUF1_SLOW;
      SFRC_OP_BUF2_FAST: return CMD_BUF2_FAST;
      SFRC_OP_BUF2_SLOW: return CMD_BUF2_SLOW;
      SFRC_OP_DUAL_READ: return CMD_DUAL;
      SFRC_OP_QUAD_READ: return CMD_QUAD;
      default: return CMD_NONE;
    endcase
  endfunction

  // dummy clocks between address and data
  function automatic logic [5:0] sfrc_dummy(input sfrc_cmd_type c);
    case (c)
      CMD_PAGE: return SFRC_PAGE_DUMMY;
      CMD_BUF1_FAST, CMD_BUF2_FAST, CMD_DUAL, CMD_QUAD: return SFRC_ONE_DUMMY;
      default: return SFRC_NO_DUMMY;
    endcase
  endfunction

  // data lanes per clock
  function automatic logic [2:0] sfrc_lanes(input sfrc_cmd_type c);
    case (c)
      CMD_DUAL: return 3'h2;
      CMD_QUAD: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // index of the last clock in a data byte, one less than its clocks
  function automatic logic [2:0] sfrc_last_chunk(input sfrc_cmd_type c);
    case (c)
      CMD_DUAL: return 3'h3;
      CMD_QUAD: return 3'h1;
      default: return 3'h7;
    endcase
  endfunction

endpackage
